// ### pttc_defs.svh
`ifndef PTTC_DEFS_SVH
`define PTTC_DEFS_SVH

// ----------------------------------------------------------------
// Unit counts and field widths.
// ----------------------------------------------------------------
`define PTTC_N_FIRE 3
`define PTTC_N_CAP 2
`define PTTC_N_PIN 2
`define PTTC_NS_W 30
`define PTTC_CNT_W 4
`define PTTC_ST_W 8
`define PTTC_FIDX_NONE 2'h3
`define PTTC_CNT_ONE 4'h1

// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define PTTC_OFS_INDEX 12'h520
`define PTTC_OFS_CTRL 12'h52C
`define PTTC_OFS_TNS 12'h530
`define PTTC_OFS_TSEC 12'h534
`define PTTC_OFS_NOTIFY 12'h538
`define PTTC_OFS_ISTAT 12'h540
`define PTTC_OFS_ICLR 12'h544
`define PTTC_OFS_IEN 12'h548
`define PTTC_OFS_CSTAT 12'h54C

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define PTTC_IDX_CAP 8
`define PTTC_IDX_PIN 16
`define PTTC_B_OSEL 8
`define PTTC_B_PIN_IN 7
`define PTTC_B_DIR 6
`define PTTC_B_CIE 5
`define PTTC_B_ACT 4
`define PTTC_B_FEN 3
`define PTTC_B_FRST 2
`define PTTC_B_CEN 1
`define PTTC_B_CRST 0
`define PTTC_B_NOTIFY 24
`define PTTC_B_RDY 4
`define PTTC_B_OVFL 5
`define PTTC_ST_DONE 0
`define PTTC_ST_ERR 3
`define PTTC_ST_CAP 6

`endif

// ### pttc_pkg.sv
`include "pttc_defs.svh"

package pttc_pkg;

  // State of one trigger (fire) unit.
  typedef struct packed {
    logic en;
    logic err;
    logic chk;
    logic fire;
    logic done_ev;
    logic err_ev;
    logic [`PTTC_NS_W-1:0] tns;
    logic [31:0] tsec;
  } pttc_fire_t;

  // State of one timestamp (capture) unit.
  typedef struct packed {
    logic en;
    logic int_en;
    logic rdy;
    logic ovfl;
    logic [`PTTC_CNT_W-1:0] cnt;
    logic ev;
  } pttc_cap_t;

  // State of the register block and pin logic.
  typedef struct packed {
    logic [1:0] fidx;
    logic cidx;
    logic pidx;
    logic [`PTTC_N_PIN-1:0] dir;
    logic [`PTTC_N_PIN-1:0] osel;
    logic [`PTTC_N_PIN-1:0] s1;
    logic [`PTTC_N_PIN-1:0] s2;
    logic [`PTTC_N_PIN-1:0] s3;
    logic [`PTTC_N_PIN-1:0] lvl;
    logic [`PTTC_N_PIN-1:0] lvl_d;
    logic [`PTTC_N_PIN-1:0] fire_d;
    logic [`PTTC_N_PIN-1:0] pout;
    logic [`PTTC_N_PIN-1:0] poe_n;
    logic [`PTTC_N_FIRE-1:0] notify;
    logic [`PTTC_ST_W-1:0] ists;
    logic [`PTTC_ST_W-1:0] ien;
    logic ack;
    logic [31:0] rdat;
    logic irq;
  } pttc_top_t;

endpackage : pttc_pkg

// ### pttc_fire_unit.sv
`timescale 1ns/1ps
`include "pttc_defs.svh"

module pttc_fire_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register strobes and write data.
  input wire logic en_wr,
  input wire logic en_val,
  input wire logic soft_rst,
  input wire logic tns_wr,
  input wire logic tsec_wr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] wmask,
  input wire logic notify,
  // Running system time.
  input wire logic [31:0] sys_sec,
  input wire logic [`PTTC_NS_W-1:0] sys_ns,
  // Unit state.
  output logic en,
  output logic active,
  output logic fire,
  output logic done_ev,
  output logic err_ev,
  output logic [`PTTC_NS_W-1:0] tns,
  output logic [31:0] tsec
);
  import pttc_pkg::*;

  pttc_fire_t q; // Registered state.
  pttc_fire_t n; // Next state.
  logic reached; // System time at or past the target.
  logic late; // System time strictly past the target.

  assign reached = {sys_sec, sys_ns} >= {q.tsec, q.tns};
  assign late = {sys_sec, sys_ns} > {q.tsec, q.tns};

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  // Target writes merge byte lanes; the enable is checked for a late
  // target once, in the cycle after it is written to one.
  always_comb begin
    n = q;
    n.fire = 1'h0;
    n.done_ev = 1'h0;
    n.err_ev = 1'h0;
    n.chk = 1'h0;
    if (tns_wr) begin
      n.tns = (q.tns & ~wmask[`PTTC_NS_W-1:0]) | (wdata[`PTTC_NS_W-1:0] & wmask[`PTTC_NS_W-1:0]);
    end
    if (tsec_wr) begin
      n.tsec = (q.tsec & ~wmask) | (wdata & wmask);
    end
    if (en_wr) begin
      n.en = en_val;
      n.chk = en_val;
      if (!en_val) begin
        n.err = 1'h0;
      end
    end else if (q.en && !q.err) begin
      if (q.chk && notify && late) begin
        n.err = 1'h1;
        n.err_ev = 1'h1;
      end else if (reached) begin
        n.en = 1'h0;
        n.fire = 1'h1;
        n.done_ev = notify;
      end
    end
    if (soft_rst) begin
      n = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign en = q.en;
  assign active = q.en & ~q.err;
  assign fire = q.fire;
  assign done_ev = q.done_ev;
  assign err_ev = q.err_ev;
  assign tns = q.tns;
  assign tsec = q.tsec;

endmodule : pttc_fire_unit

// ### pttc_cap_unit.sv
`timescale 1ns/1ps
`include "pttc_defs.svh"

module pttc_cap_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register strobes.
  input wire logic en_wr,
  input wire logic en_val,
  input wire logic ie_wr,
  input wire logic ie_val,
  input wire logic soft_rst,
  // Qualified input edge of the unit's pin.
  input wire logic pin_edge,
  // Unit state.
  output logic en,
  output logic int_en,
  output logic rdy,
  output logic ovfl,
  output logic [`PTTC_CNT_W-1:0] cnt,
  output logic ev
);
  import pttc_pkg::*;

  pttc_cap_t q; // Registered state.
  pttc_cap_t n; // Next state.

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  // An edge in the same cycle as an enable write counts only if the unit was already enabled; a soft reset in that cycle drops it.
  always_comb begin
    n = q;
    n.ev = 1'h0;
    if (ie_wr) begin
      n.int_en = ie_val;
    end
    if (en_wr) begin
      n.en = en_val;
      if (en_val) begin
        n.cnt = '0;
      end else begin
        n.rdy = 1'h0;
        n.ovfl = 1'h0;
      end
    end
    if (q.en && pin_edge) begin
      n.rdy = 1'h1;
      n.ev = q.int_en;
      if (&n.cnt) begin
        n.ovfl = 1'h1;
      end else begin
        n.cnt = n.cnt + `PTTC_CNT_ONE;
      end
    end
    if (soft_rst) begin
      n = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign en = q.en;
  assign int_en = q.int_en;
  assign rdy = q.rdy;
  assign ovfl = q.ovfl;
  assign cnt = q.cnt;
  assign ev = q.ev;

endmodule : pttc_cap_unit

// ### pttc_top.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "pttc_defs.svh"

// Behaviour
// - Index selects trigger, timestamp and pin units.
// - Output select: direct or extra-flopped pin drive.
// - Bit 7 reads the indexed pin level.
// - Bit 6: 1 pin input, 0 output.
// - Bit 5 gates timestamp unit interrupt.
// - Bit 4 reads trigger active without error.
// - Bit 3 enables trigger; clears on firing.
// - Bit 2 soft-resets the indexed trigger unit.
// - Timestamp enable one clears event counter.
// - Timestamp enable zero clears ready, overflow.
// - Bit 0 soft-resets the indexed timestamp unit.
// - Thirty-bit nanosecond target, top bits zero.
// - Thirty-two-bit seconds target, reset zero.
// - Done, error reported only with notify set.
// - Late target flags error; enable zero clears.
module pttc_top (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // Wishbone slave.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // System time from the local clock logic.
  input wire logic [31:0] SYS_SEC,
  input wire logic [`PTTC_NS_W-1:0] SYS_NS,
  // Event pins, split into input, output and enable.
  input wire logic [`PTTC_N_PIN-1:0] PIN_IN,
  output logic [`PTTC_N_PIN-1:0] PIN_OUT,
  output logic [`PTTC_N_PIN-1:0] PIN_OE_N,
  // Interrupt.
  output logic IRQ
);
  import pttc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  pttc_top_t q; // Registered state.
  pttc_top_t n; // Next state.

  logic req; // New bus request this cycle.
  logic wr; // New write request.
  logic [11:0] wa; // Word-aligned byte address.
  logic [31:0] m; // Byte-lane mask.
  logic [31:0] wd; // Masked write data.
  logic hit_ctrl; // Write to the control and status register.
  logic fv; // Trigger index names an existing unit.
  logic [1:0] fi; // Safe trigger index.

  logic [`PTTC_N_FIRE-1:0] f_sel; // Trigger unit chosen by the index.
  logic [`PTTC_N_FIRE-1:0] f_en_wr; // Trigger enable written.
  logic [`PTTC_N_FIRE-1:0] f_srst; // Trigger soft reset.
  logic [`PTTC_N_FIRE-1:0] f_tns_wr; // Nanosecond target written.
  logic [`PTTC_N_FIRE-1:0] f_tsec_wr; // Seconds target written.
  logic [`PTTC_N_FIRE-1:0] f_en; // Trigger enabled.
  logic [`PTTC_N_FIRE-1:0] f_act; // Trigger active.
  logic [`PTTC_N_FIRE-1:0] f_fire; // Trigger fire pulse.
  logic [`PTTC_N_FIRE-1:0] f_done; // Reported done event.
  logic [`PTTC_N_FIRE-1:0] f_err; // Reported error event.
  logic [`PTTC_NS_W-1:0] f_tns [`PTTC_N_FIRE]; // Nanosecond targets.
  logic [31:0] f_tsec [`PTTC_N_FIRE]; // Seconds targets.

  logic [`PTTC_N_CAP-1:0] c_sel; // Timestamp unit chosen by the index.
  logic [`PTTC_N_CAP-1:0] c_en_wr; // Timestamp enable written.
  logic [`PTTC_N_CAP-1:0] c_ie_wr; // Interrupt enable written.
  logic [`PTTC_N_CAP-1:0] c_srst; // Timestamp soft reset.
  logic [`PTTC_N_CAP-1:0] c_edge; // Qualified input edge.
  logic [`PTTC_N_CAP-1:0] c_en; // Timestamp enabled.
  logic [`PTTC_N_CAP-1:0] c_ie; // Timestamp interrupt enabled.
  logic [`PTTC_N_CAP-1:0] c_rdy; // Capture ready.
  logic [`PTTC_N_CAP-1:0] c_ovfl; // Count overflow.
  logic [`PTTC_N_CAP-1:0] c_ev; // Interrupt event.
  logic [`PTTC_CNT_W-1:0] c_cnt [`PTTC_N_CAP]; // Event counts.

  logic [`PTTC_N_PIN-1:0] pin_src; // Fire pulses routed to each pin.
  logic [`PTTC_N_PIN-1:0] pin_rise; // Filtered rising edge per pin.

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  // A request is taken once; the ack flop blocks a second take.
  assign req = WB_CYC_I & WB_STB_I & ~q.ack;
  assign wr = req & WB_WE_I;
  assign wa = {WB_ADR_I[11:2], 2'h0};
  assign m = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wd = WB_DAT_I & m;
  assign hit_ctrl = wr && (wa == `PTTC_OFS_CTRL);
  assign fv = q.fidx != `PTTC_FIDX_NONE;
  assign fi = fv ? q.fidx : 2'h0;

  // Pin 0 carries trigger units 0 and 2, pin 1 carries unit 1.
  assign pin_src = {f_fire[1], f_fire[0] | f_fire[2]};
  assign pin_rise = q.lvl & ~q.lvl_d;

  // ----------------------------------------------------------------
  // Trigger units.
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `PTTC_N_FIRE; i++) begin : g_fire
    // Strobes reach only the unit named by the trigger index.
    assign f_sel[i] = q.fidx == 2'(i);
    assign f_en_wr[i] = hit_ctrl & f_sel[i] & m[`PTTC_B_FEN];
    assign f_srst[i] = hit_ctrl & f_sel[i] & wd[`PTTC_B_FRST];
    assign f_tns_wr[i] = wr & (wa == `PTTC_OFS_TNS) & f_sel[i];
    assign f_tsec_wr[i] = wr & (wa == `PTTC_OFS_TSEC) & f_sel[i];

    pttc_fire_unit u_fire (
      .clk(CLK),
      .srst(SRST),
      .en_wr(f_en_wr[i]),
      .en_val(WB_DAT_I[`PTTC_B_FEN]),
      .soft_rst(f_srst[i]),
      .tns_wr(f_tns_wr[i]),
      .tsec_wr(f_tsec_wr[i]),
      .wdata(WB_DAT_I),
      .wmask(m),
      .notify(q.notify[i]),
      .sys_sec(SYS_SEC),
      .sys_ns(SYS_NS),
      .en(f_en[i]),
      .active(f_act[i]),
      .fire(f_fire[i]),
      .done_ev(f_done[i]),
      .err_ev(f_err[i]),
      .tns(f_tns[i]),
      .tsec(f_tsec[i])
    );
  end

  // ----------------------------------------------------------------
  // Timestamp units.
  // ----------------------------------------------------------------
  for (genvar j = 0; j < `PTTC_N_CAP; j++) begin : g_cap
    assign c_sel[j] = q.cidx == 1'(j);
    assign c_en_wr[j] = hit_ctrl & c_sel[j] & m[`PTTC_B_CEN];
    assign c_ie_wr[j] = hit_ctrl & c_sel[j] & m[`PTTC_B_CIE];
    assign c_srst[j] = hit_ctrl & c_sel[j] & wd[`PTTC_B_CRST];
    // Only a pin set as an input feeds its timestamp unit.
    assign c_edge[j] = pin_rise[j] & q.dir[j];

    pttc_cap_unit u_cap (
      .clk(CLK),
      .srst(SRST),
      .en_wr(c_en_wr[j]),
      .en_val(WB_DAT_I[`PTTC_B_CEN]),
      .ie_wr(c_ie_wr[j]),
      .ie_val(WB_DAT_I[`PTTC_B_CIE]),
      .soft_rst(c_srst[j]),
      .pin_edge(c_edge[j]),
      .en(c_en[j]),
      .int_en(c_ie[j]),
      .rdy(c_rdy[j]),
      .ovfl(c_ovfl[j]),
      .cnt(c_cnt[j]),
      .ev(c_ev[j])
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  // Fills the bus answer, register writes, pin path and interrupt.
  always_comb begin
    logic [31:0] rd;
    logic [`PTTC_ST_W-1:0] set;
    logic [`PTTC_ST_W-1:0] clr;
    rd = '0;
    set = '0;
    clr = '0;
    n = q;

    // Bus answer: one ack per request, unmapped reads return zero.
    n.ack = req;
    case (wa)
      `PTTC_OFS_INDEX: begin
        rd[1:0] = q.fidx;
        rd[`PTTC_IDX_CAP] = q.cidx;
        rd[`PTTC_IDX_PIN] = q.pidx;
      end
      `PTTC_OFS_CTRL: begin
        // Upper bits stay zero.
        rd[`PTTC_B_OSEL] = q.osel[q.pidx];
        rd[`PTTC_B_PIN_IN] = q.lvl[q.pidx];
        rd[`PTTC_B_DIR] = q.dir[q.pidx];
        rd[`PTTC_B_CIE] = c_ie[q.cidx];
        rd[`PTTC_B_ACT] = fv & f_act[fi];
        rd[`PTTC_B_FEN] = fv & f_en[fi];
        rd[`PTTC_B_CEN] = c_en[q.cidx];
      end
      `PTTC_OFS_TNS: begin
        rd[`PTTC_NS_W-1:0] = fv ? f_tns[fi] : '0;
      end
      `PTTC_OFS_TSEC: begin
        rd = fv ? f_tsec[fi] : '0;
      end
      `PTTC_OFS_NOTIFY: begin
        rd[`PTTC_B_NOTIFY] = fv & q.notify[fi];
      end
      `PTTC_OFS_ISTAT: begin
        rd[`PTTC_ST_W-1:0] = q.ists;
      end
      `PTTC_OFS_IEN: begin
        rd[`PTTC_ST_W-1:0] = q.ien;
      end
      `PTTC_OFS_CSTAT: begin
        rd[`PTTC_CNT_W-1:0] = c_cnt[q.cidx];
        rd[`PTTC_B_RDY] = c_rdy[q.cidx];
        rd[`PTTC_B_OVFL] = c_ovfl[q.cidx];
      end
      default: begin
        rd = '0;
      end
    endcase
    if (req && !WB_WE_I) begin
      n.rdat = rd;
    end

    // Register writes, byte lane by byte lane.
    if (wr) begin
      case (wa)
        `PTTC_OFS_INDEX: begin
          if (m[0]) begin
            n.fidx = wd[1:0];
          end
          if (m[`PTTC_IDX_CAP]) begin
            n.cidx = wd[`PTTC_IDX_CAP];
          end
          if (m[`PTTC_IDX_PIN]) begin
            n.pidx = wd[`PTTC_IDX_PIN];
          end
        end
        `PTTC_OFS_CTRL: begin
          if (m[`PTTC_B_OSEL]) begin
            n.osel[q.pidx] = wd[`PTTC_B_OSEL];
          end
          if (m[`PTTC_B_DIR]) begin
            n.dir[q.pidx] = wd[`PTTC_B_DIR];
          end
        end
        `PTTC_OFS_NOTIFY: begin
          if (fv && m[`PTTC_B_NOTIFY]) begin
            n.notify[fi] = wd[`PTTC_B_NOTIFY];
          end
        end
        `PTTC_OFS_ICLR: begin
          clr = wd[`PTTC_ST_W-1:0];
        end
        `PTTC_OFS_IEN: begin
          n.ien = (q.ien & ~m[`PTTC_ST_W-1:0]) | wd[`PTTC_ST_W-1:0];
        end
        default: begin
          n.ien = q.ien;
        end
      endcase
    end

    // Writing a trigger enable to zero drops its error status.
    for (int k = 0; k < `PTTC_N_FIRE; k++) begin
      if (f_en_wr[k] && !WB_DAT_I[`PTTC_B_FEN]) begin
        clr[`PTTC_ST_ERR + k] = 1'h1;
      end
    end
    // A trigger soft reset returns its notify bit to default.
    n.notify = n.notify & ~f_srst;

    // Sticky status: a new event wins over a clear in the same cycle.
    set[`PTTC_ST_DONE +: `PTTC_N_FIRE] = f_done;
    set[`PTTC_ST_ERR +: `PTTC_N_FIRE] = f_err;
    set[`PTTC_ST_CAP +: `PTTC_N_CAP] = c_ev;
    n.ists = (q.ists & ~clr) | set;
    n.irq = |(q.ists & q.ien);

    // Pin input: three flops, a change counts once s2 and s3 agree.
    n.s1 = PIN_IN;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.lvl = (q.lvl & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
    n.lvl_d = q.lvl;

    // Pin output: direct source, or one more flop when select is zero.
    n.fire_d = pin_src;
    n.pout = (q.osel & pin_src) | (~q.osel & q.fire_d);
    n.poe_n = q.dir;
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops.
  // ----------------------------------------------------------------
  assign WB_DAT_O = q.rdat;
  assign WB_ACK_O = q.ack;
  assign PIN_OUT = q.pout;
  assign PIN_OE_N = q.poe_n;
  assign IRQ = q.irq;

endmodule : pttc_top

// ### pttc_monitor.sv
`timescale 1ns/1ps
`include "pttc_defs.svh"

// ------------------------------------------------------------
// Port-level checker for the event unit register block.
// ------------------------------------------------------------
module pttc_monitor (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // Wishbone slave.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Pins and interrupt.
  input wire logic [`PTTC_N_PIN-1:0] PIN_OUT,
  input wire logic [`PTTC_N_PIN-1:0] PIN_OE_N,
  input wire logic IRQ
);
  default clocking
    @(posedge CLK);
  endclocking
  default disable iff (SRST);

  logic take; // A request is taken when presented with no answer pending.
  logic pidx_ff; // Pin index last written by software.
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // Follows the pin index so a direction write can be tied to its pin.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pidx_ff <= 1'b0;
    end else if (take && WB_WE_I && WB_ADR_I == `PTTC_OFS_INDEX && WB_SEL_I[2]) begin
      pidx_ff <= WB_DAT_I[`PTTC_IDX_PIN];
    end
  end

  chk_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_after_req: assert property (take |=> WB_ACK_O)
    else $error("request not answered in one cycle");
  chk_rdat_holds: assert property (!(take && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("read data changed without a read");
  chk_ctrl_rsvd_zero: assert property (
    take && !WB_WE_I && WB_ADR_I == `PTTC_OFS_CTRL |=> WB_DAT_O[31:9] == 23'h0)
    else $error("control reserved bits not zero");
  chk_tns_rsvd_zero: assert property (
    take && !WB_WE_I && WB_ADR_I == `PTTC_OFS_TNS |=> WB_DAT_O[31:30] == 2'h0)
    else $error("target ns top bits not zero");
  chk_dir_to_oe: assert property (
    take && WB_WE_I && WB_ADR_I == `PTTC_OFS_CTRL && WB_SEL_I[0]
    |-> ##2 PIN_OE_N[pidx_ff] == $past(WB_DAT_I[`PTTC_B_DIR], 2))
    else $error("pin enable does not follow direction");
  chk_irq_masked: assert property (
    take && WB_WE_I && WB_ADR_I == `PTTC_OFS_IEN && WB_SEL_I[0] && WB_DAT_I[7:0] == 8'h00
    |-> ##2 !IRQ [*3])
    else $error("interrupt high with all enables off");
  chk_pout_pulse: assert property ($rose(PIN_OUT[0]) |=> $fell(PIN_OUT[0]))
    else $error("fire pulse longer than one cycle");
  chk_pout1_pulse: assert property ($rose(PIN_OUT[1]) |=> $fell(PIN_OUT[1]))
    else $error("pin 1 fire pulse longer than one cycle");

  cov_fire: cover property ($rose(PIN_OUT[0]));
  cov_irq: cover property ($rose(IRQ));
  cov_pin_in: cover property ($rose(PIN_OE_N[1]));
endmodule : pttc_monitor

// ### tb_top.sv
`timescale 1ns/1ps
`include "pttc_defs.svh"

bind pttc_top pttc_monitor mon (.CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PIN_OUT(PIN_OUT),
  .PIN_OE_N(PIN_OE_N), .IRQ(IRQ));

// ------------------------------------------------------------
// Bench top: drives the register bus, system time and pins.
// ------------------------------------------------------------
module tb_top;
  logic clk, srst, cyc, stb, we, ack, irq;
  logic [11:0] adr;
  logic [3:0] sel, bsel;
  logic [31:0] wdat, rdat, sec, d;
  logic [29:0] ns, tgt;
  logic [1:0] pin_in, pin_out, pin_oe_n;
  logic [31:0] tv [3];
  logic [31:0] sv [3];
  integer seed, miscompares, n_tests, k, n;
  integer lat [2];

  pttc_top dut (.CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SYS_SEC(sec), .SYS_NS(ns), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .IRQ(irq));

  // Clock of 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // System time advances by one clock period each cycle.
  always @(posedge clk) begin
    ns <= ns + 30'h32;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Expected event count: the counter stops at its top value.
  function automatic logic [31:0] exp_cnt(input integer c);
    exp_cnt = (c > 15) ? 32'hF : c;
  endfunction : exp_cnt

  // One classic bus cycle; read data is taken at the acknowledging edge.
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] v);
    integer i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= a;
    wdat <= v;
    for (i = 0; i < 20 && ack !== 1'b1; i++) begin
      @(posedge clk);
    end
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares = miscompares + 1;
      test_done();
    end
  endtask : wb

  // Reads a register and compares the masked value.
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(d & m, e);
  endtask : rc

  // Rising edges on pin 1, slow enough for the input filter.
  task automatic pulse(input integer c);
    repeat (c) begin
      pin_in[1] <= 1'b1;
      repeat (8) @(posedge clk);
      pin_in[1] <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulse

  // Arms one trigger unit and counts cycles from target reached to pin pulse.
  task automatic fire(input integer u, input integer o);
    integer i;
    tgt = ns + 30'hBB8;
    wb(1'b1, `PTTC_OFS_INDEX, u);
    wb(1'b1, `PTTC_OFS_TNS, {2'h0, tgt});
    wb(1'b1, `PTTC_OFS_TSEC, sec);
    wb(1'b1, `PTTC_OFS_CTRL, o ? 32'h108 : 32'h8);
    rc(`PTTC_OFS_CTRL, 32'h18, 32'h18);
    lat[o] = -1;
    for (i = 0; i < 200 && pin_out[u % 2] !== 1'b1; i++) begin
      @(posedge clk);
      if (lat[o] >= 0) begin
        lat[o] = lat[o] + 1;
      end else if (ns >= tgt) begin
        lat[o] = 0;
      end
    end
    if (pin_out[u % 2] !== 1'b1) begin
      miscompares = miscompares + 1;
      test_done();
    end
  endtask : fire

  // Main sequence.
  initial begin
    seed = 32'h7815;
    miscompares = 0;
    n_tests = 0;
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h0;
    sel = 4'hF;
    bsel = 4'hF;
    wdat = 32'h0;
    ns = 30'h0;
    pin_in = 2'h0;
    sec = $random(seed) | 32'h10;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rc(`PTTC_OFS_TNS, 32'hFFFFFFFF, 32'h0);
    rc(`PTTC_OFS_TSEC, 32'hFFFFFFFF, 32'h0);
    rc(`PTTC_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    // An unmapped place ignores writes and reads zero.
    wb(1'b1, 12'h000, 32'hFFFFFFFF);
    rc(12'h000, 32'hFFFFFFFF, 32'h0);
    // Each trigger unit keeps its own targets; index 3 selects none.
    for (k = 0; k < 3; k++) begin
      tv[k] = $random(seed);
      sv[k] = $random(seed);
      wb(1'b1, `PTTC_OFS_INDEX, k);
      wb(1'b1, `PTTC_OFS_TNS, tv[k]);
      wb(1'b1, `PTTC_OFS_TSEC, sv[k]);
    end
    for (k = 0; k < 3; k++) begin
      wb(1'b1, `PTTC_OFS_INDEX, k);
      rc(`PTTC_OFS_TNS, 32'hFFFFFFFF, tv[k] & 32'h3FFFFFFF);
      rc(`PTTC_OFS_TSEC, 32'hFFFFFFFF, sv[k]);
    end
    // A write with one byte lane enabled changes only that byte.
    bsel = 4'h1;
    wb(1'b1, `PTTC_OFS_TSEC, 32'hFFFFFFFF);
    bsel = 4'hF;
    rc(`PTTC_OFS_TSEC, 32'hFFFFFFFF, sv[2] | 32'hFF);
    wb(1'b1, `PTTC_OFS_INDEX, 32'h3);
    rc(`PTTC_OFS_TNS, 32'hFFFFFFFF, 32'h0);
    // Trigger unit 0 with notify and all interrupts enabled.
    wb(1'b1, `PTTC_OFS_INDEX, 32'h0);
    wb(1'b1, `PTTC_OFS_NOTIFY, 32'h01000000);
    wb(1'b1, `PTTC_OFS_IEN, 32'hFF);
    fire(0, 1);
    fire(0, 0);
    chk(lat[0], lat[1] + 1);
    rc(`PTTC_OFS_CTRL, 32'h18, 32'h0);
    rc(`PTTC_OFS_ISTAT, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, `PTTC_OFS_ICLR, 32'hFF);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // A target already in the past gives an error, not a pulse.
    wb(1'b1, `PTTC_OFS_TSEC, sec - 32'h1);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h8);
    rc(`PTTC_OFS_ISTAT, 32'h8, 32'h8);
    rc(`PTTC_OFS_CTRL, 32'h18, 32'h8);
    wb(1'b1, `PTTC_OFS_IEN, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h0);
    rc(`PTTC_OFS_ISTAT, 32'h8, 32'h0);
    // Soft reset of an armed trigger unit.
    wb(1'b1, `PTTC_OFS_TSEC, sec + 32'h1);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h8);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h4);
    rc(`PTTC_OFS_CTRL, 32'h18, 32'h0);
    rc(`PTTC_OFS_TSEC, 32'hFFFFFFFF, 32'h0);
    // Trigger unit 1 drives pin 1 through the flopped path.
    fire(1, 0);
    chk(lat[0], lat[1] + 1);
    // Pin 1 as a timestamp input feeding timestamp unit 1.
    wb(1'b1, `PTTC_OFS_IEN, 32'hFF);
    wb(1'b1, `PTTC_OFS_INDEX, 32'h10103);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h40);
    repeat (2) @(posedge clk);
    chk({30'h0, pin_oe_n}, 32'h2);
    pin_in[1] <= 1'b1;
    repeat (10) @(posedge clk);
    rc(`PTTC_OFS_CTRL, 32'h80, 32'h80);
    pin_in[1] <= 1'b0;
    repeat (10) @(posedge clk);
    rc(`PTTC_OFS_CTRL, 32'h80, 32'h0);
    n = ($random(seed) & 7) + 1;
    wb(1'b1, `PTTC_OFS_CTRL, 32'h62);
    pulse(n);
    rc(`PTTC_OFS_CSTAT, 32'hF, exp_cnt(n));
    rc(`PTTC_OFS_ISTAT, 32'h80, 32'h80);
    pulse(16);
    rc(`PTTC_OFS_CSTAT, 32'h2F, exp_cnt(n + 16) | 32'h20);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h60);
    rc(`PTTC_OFS_CSTAT, 32'h30, 32'h0);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h62);
    rc(`PTTC_OFS_CSTAT, 32'hF, 32'h0);
    pulse(1);
    wb(1'b1, `PTTC_OFS_CTRL, 32'h61);
    rc(`PTTC_OFS_CSTAT, 32'hF, 32'h0);
    rc(`PTTC_OFS_CTRL, 32'h2, 32'h0);
    test_done();
  end
endmodule : tb_top
